// [hdl/pmq_pkg.sv]
// Behaviour
// RULE1: Packet mode chosen when packet select is high at master reset release.
// RULE2: Writer makes each packet at least four words, markers included.
// RULE3: In packet mode the almost-empty bus carries packet-ready status.
// RULE4: Packet available only while packet-ready and output-valid flags are both low.
// RULE5: Writer completes a packet before switching write queue.
// RULE6: Write queue switch takes two cycles; address sampled with the strobe.
// RULE7: Switch-request cycle stores into old queue only when write enable low.
// RULE8: Writer puts one filler word into old queue after the switch request.
// RULE9: Writer sends no marker word in the cycle after a switch request.
// RULE10: Full flag shows the new queue from the edge after the request.
// RULE11: New queue written from the second edge on; full queue blocks writes.
// RULE12: Reader takes the whole packet before requesting a read queue switch.
// RULE13: Read switch cycle delivers old word only with read and output enables low.
// RULE14: Reader reads no marker word in the cycle after a read switch.
// RULE15: After a read switch, old filler comes out, then new queue first word.
// RULE16: Reader discards the filler word shown after a queue switch.
// RULE17: Ready status kept per queue; selected read queue drives the single flag.
// RULE18: No word leaves a queue until it holds a complete packet; RD_FILL pops the old queue's word whenever it is not empty and the read control bit is set.
// RULE19: Ready bus polled or direct by flag mode latched at reset; eight queues.
// RULE20: Packet mode only with 36-bit write and read data buses.
// RULE21: Bit 34 marks start, bit 35 end; stored with word and returned.
// RULE22: Flag strobe with read strobe low picks quadrant of eight queues.
// RULE23: Read queue taken from address at edge with read strobe high.
// RULE24: Per-queue counter counts end after start, decremented as packets leave.
// RULE25: Write and read logic kept apart; status crossing them stays safe.
`default_nettype none
package pmq_pkg;
    localparam int DATA_W      = 36; // RULE20
    localparam int START_BIT   = 34;
    localparam int END_BIT     = 35;
    localparam int NUM_Q       = 32;
    localparam int QSEL_W      = 5;
    localparam int QUAD_W      = 2;
    localparam int QUAD_SIZE   = 8;
    localparam int QADDR_W     = 8;
    localparam int QUEUE_DEPTH = 16;
    localparam int AVS_AW      = 4;
    localparam logic [3:0] OFF_CTRL   = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_READY  = 4'h8;
    localparam int CTRL_WR_POS  = 0;
    localparam int CTRL_RD_POS  = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam int STAT_WRQ_LSB = 0;
    localparam int STAT_RDQ_LSB = 8;
    localparam int STAT_PKT_POS = 16;
    localparam int STAT_FM_POS  = 17;
    typedef enum logic [1:0] {RD_NORM, RD_FILL, RD_FIRST} pmq_rd_state_e;
endpackage
`default_nettype wire

// [hdl/pmq_q_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface pmq_q_if;
    import pmq_pkg::*;
    logic              push;
    logic              pop;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              full;
    logic              empty;
    logic              ready;
    logic              in_pkt;
    modport store (input push, input pop, input wdata, output rdata, output full, output empty);
    modport count (input push, input pop, input wdata, input rdata, output ready, output in_pkt);
endinterface
`default_nettype wire

// [hdl/pmq_queue_store.sv]
`timescale 1ns/1ps
`default_nettype none
// One queue; depth must be a power of two so pointers wrap freely
module pmq_queue_store
    import pmq_pkg::*;
#(
    parameter int DEPTH = QUEUE_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Queue side
    pmq_q_if.store   q
);
    localparam int AW = $clog2(DEPTH);
    logic [DATA_W-1:0] mem_reg [DEPTH];
    logic [AW-1:0]     wr_ptr_reg;
    logic [AW-1:0]     rd_ptr_reg;
    logic [AW:0]       cnt_reg;
    wire do_push = q.push && !q.full;
    wire do_pop  = q.pop && !q.empty;
    assign q.full  = (cnt_reg == (AW+1)'(DEPTH));
    assign q.empty = (cnt_reg == '0);
    assign q.rdata = mem_reg[rd_ptr_reg];
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_reg[wr_ptr_reg] <= q.wdata;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + AW'(do_push);
            rd_ptr_reg <= rd_ptr_reg + AW'(do_pop);
            cnt_reg    <= cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule
`default_nettype wire

// [hdl/pmq_pkt_count.sv]
`timescale 1ns/1ps
`default_nettype none
module pmq_pkt_count
    import pmq_pkg::*;
#(
    parameter int CNT_W = $clog2(QUEUE_DEPTH) + 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Queue side
    pmq_q_if.count   q
);
    logic             seen_start_reg;
    logic             rd_in_pkt_reg;
    logic [CNT_W-1:0] cnt_reg;
    // Repeated start or end markers are ignored, so a doubled end works as filler
    wire inc      = q.push && q.wdata[END_BIT] && seen_start_reg; // RULE24
    wire dec      = q.pop && q.rdata[START_BIT] && !rd_in_pkt_reg && q.ready; // RULE24
    wire rd_close = q.pop && q.rdata[END_BIT] && rd_in_pkt_reg;
    assign q.ready  = (cnt_reg != '0); // RULE17
    assign q.in_pkt = rd_in_pkt_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_start_reg <= 1'b0;
            rd_in_pkt_reg  <= 1'b0;
            cnt_reg        <= '0;
        end else begin
            if (inc) begin
                seen_start_reg <= 1'b0;
            end else if (q.push && q.wdata[START_BIT]) begin
                seen_start_reg <= 1'b1;
            end
            if (dec) begin
                rd_in_pkt_reg <= 1'b1;
            end else if (rd_close) begin
                rd_in_pkt_reg <= 1'b0;
            end
            cnt_reg <= cnt_reg + CNT_W'(inc) - CNT_W'(dec);
        end
    end
endmodule
`default_nettype wire

// [hdl/pmq_top.sv]
`timescale 1ns/1ps
`default_nettype none
module pmq_top
    import pmq_pkg::*;
#(
    parameter int DEPTH = QUEUE_DEPTH
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Mode straps
    input  wire logic               packet_select,
    input  wire logic               flag_mode_select,
    // Write port
    input  wire logic               write_en_n,
    input  wire logic [DATA_W-1:0]  write_data,
    input  wire logic               write_addr_strobe,
    input  wire logic [QADDR_W-1:0] write_queue_addr,
    output var  logic               full_flag_n,
    // Read port
    input  wire logic               read_en_n,
    input  wire logic               output_en_n,
    input  wire logic               read_addr_strobe,
    input  wire logic               read_flag_strobe,
    input  wire logic [QADDR_W-1:0] read_queue_addr,
    output var  logic [DATA_W-1:0]  read_data,
    output var  logic               read_data_oe,
    output var  logic               output_valid_flag_n,
    output var  logic               packet_ready_flag_n,
    output var  logic [7:0]         packet_ready_bus_n,
    output var  logic [QUAD_W-1:0]  packet_ready_quad,
    // Avalon-MM slave
    input  wire logic [AVS_AW-1:0]  avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    output var  logic [31:0]        avs_readdata,
    output var  logic               avs_waitrequest
);
    // Mode latch
    logic latched_reg;
    logic pkt_mode_reg;
    logic flag_mode_reg;
    // Software control
    logic [1:0] ctrl_reg;
    // Write side
    logic [QSEL_W-1:0] wr_q_reg;
    logic [QSEL_W-1:0] wr_q_pend_reg;
    logic              wr_sw_reg;
    logic              full_n_reg;
    // Read side
    pmq_rd_state_e     rd_st_reg;
    pmq_rd_state_e     rd_st_next;
    logic [QSEL_W-1:0] rd_q_reg;
    logic [QSEL_W-1:0] rd_q_pend_reg;
    logic [DATA_W-1:0] q_out_reg;
    logic              q_oe_reg;
    logic              ov_n_reg;
    logic              pr_n_reg;
    logic [7:0]        bus_n_reg;
    logic [QUAD_W-1:0] poll_quad_reg;
    logic [QUAD_W-1:0] dir_quad_reg;
    logic [QUAD_W-1:0] quad_out_reg;
    // Bus slave
    logic        wait_reg;
    logic [31:0] rdata_reg;
    logic [31:0] status_word;
    // Per-queue views
    logic [NUM_Q-1:0]  full_vec;
    logic [NUM_Q-1:0]  empty_vec;
    logic [NUM_Q-1:0]  ready_vec;
    logic [NUM_Q-1:0]  in_pkt_vec;
    logic [DATA_W-1:0] rdata_arr [NUM_Q];

    // Write-side decode
    wire wr_req   = write_addr_strobe && !wr_sw_reg; // RULE6
    wire wr_allow = ctrl_reg[CTRL_WR_POS] && latched_reg;
    // Old queue stays target for request and filler cycles
    wire wr_push  = !write_en_n && !full_vec[wr_q_reg] && wr_allow; // RULE7 RULE11
    wire [QSEL_W-1:0] wr_q_show = wr_sw_reg ? wr_q_pend_reg : wr_q_reg; // RULE10

    // Read-side decode
    wire rd_req    = read_addr_strobe && (rd_st_reg == RD_NORM); // RULE23
    wire rd_allow  = ctrl_reg[CTRL_RD_POS] && latched_reg;
    wire rd_cur_ok = !empty_vec[rd_q_reg]
                     && (!pkt_mode_reg || ready_vec[rd_q_reg] || in_pkt_vec[rd_q_reg]); // RULE18
    wire rd_norm   = !read_en_n && (!read_addr_strobe || !output_en_n)
                     && rd_cur_ok && rd_allow; // RULE13
    wire rd_fill   = !empty_vec[rd_q_reg] && rd_allow; // RULE15
    wire rd_pop    = (rd_st_reg == RD_NORM) ? rd_norm
                   : (rd_st_reg == RD_FILL) ? rd_fill
                   : (rd_cur_ok && rd_allow); // RULE15
    wire [DATA_W-1:0] rd_word = rdata_arr[rd_q_reg];
    wire ov_n_next = rd_pop ? 1'b0
                   : ((rd_st_reg != RD_NORM) || !read_en_n) ? 1'b1 : ov_n_reg;

    // Ready bus quadrant
    wire rd_flag_sel = read_flag_strobe && !read_addr_strobe; // RULE22
    wire [QUAD_W-1:0] dir_quad_next = rd_flag_sel ? read_queue_addr[QUAD_W-1:0] : dir_quad_reg;
    wire [QUAD_W-1:0] quad_cur = flag_mode_reg ? poll_quad_reg : dir_quad_next; // RULE19
    // Standard mode shows emptiness, packet mode shows packet readiness
    wire [NUM_Q-1:0] stat_n_vec = pkt_mode_reg ? ~ready_vec : ~empty_vec; // RULE3
    wire [7:0] bus_n_next = stat_n_vec[{quad_cur, 3'h0} +: QUAD_SIZE]; // RULE19

    // Register decode
    wire avs_req  = (avs_read || avs_write) && wait_reg;
    wire hit_ctrl = (avs_address == OFF_CTRL);
    wire ctrl_wr  = avs_write && !wait_reg && hit_ctrl;
    wire [31:0] reg_mux = hit_ctrl                    ? {30'h0, ctrl_reg}
                        : (avs_address == OFF_STATUS) ? status_word
                        : (avs_address == OFF_READY)  ? ready_vec
                        : 32'h0;

    always_comb begin
        status_word = 32'h0;
        status_word[STAT_WRQ_LSB +: QSEL_W] = wr_q_reg;
        status_word[STAT_RDQ_LSB +: QSEL_W] = rd_q_reg;
        status_word[STAT_PKT_POS] = pkt_mode_reg;
        status_word[STAT_FM_POS]  = flag_mode_reg;
    end

    always_comb begin
        case (rd_st_reg)
            RD_NORM:  rd_st_next = rd_req ? RD_FILL : RD_NORM;
            RD_FILL:  rd_st_next = RD_FIRST;
            RD_FIRST: rd_st_next = RD_NORM;
            default:  rd_st_next = RD_NORM;
        endcase
    end

    // Queue storage and packet counters, one pair per queue
    generate
        for (genvar i = 0; i < NUM_Q; i++) begin : g_q
            pmq_q_if qif ();
            assign qif.push  = wr_push && (wr_q_reg == QSEL_W'(i));
            assign qif.pop   = rd_pop && (rd_q_reg == QSEL_W'(i));
            assign qif.wdata = write_data; // RULE21
            assign full_vec[i]   = qif.full;
            assign empty_vec[i]  = qif.empty;
            // One clock for both ports, so status needs no synchroniser
            assign ready_vec[i]  = qif.ready; // RULE25
            assign in_pkt_vec[i] = qif.in_pkt;
            assign rdata_arr[i]  = qif.rdata;
            pmq_queue_store #(.DEPTH(DEPTH)) u_store (
                .clk   (clk),
                .rst_n (rst_n),
                .q     (qif)
            );
            pmq_pkt_count #(.CNT_W($clog2(DEPTH) + 1)) u_count (
                .clk   (clk),
                .rst_n (rst_n),
                .q     (qif)
            );
        end
    endgenerate

    // Straps taken at the first edge after reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latched_reg   <= 1'b0;
            pkt_mode_reg  <= 1'b0;
            flag_mode_reg <= 1'b0;
        end else if (!latched_reg) begin
            latched_reg   <= 1'b1;
            pkt_mode_reg  <= packet_select; // RULE1
            flag_mode_reg <= flag_mode_select; // RULE19
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q_reg      <= '0;
            wr_q_pend_reg <= '0;
            wr_sw_reg     <= 1'b0;
            full_n_reg    <= 1'b1;
        end else begin
            if (wr_sw_reg) begin
                wr_q_reg  <= wr_q_pend_reg; // RULE6
                wr_sw_reg <= 1'b0;
            end else if (wr_req) begin
                wr_q_pend_reg <= write_queue_addr[QSEL_W-1:0];
                wr_sw_reg     <= 1'b1;
            end
            full_n_reg <= !full_vec[wr_q_show]; // RULE10
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_st_reg     <= RD_NORM;
            rd_q_reg      <= '0;
            rd_q_pend_reg <= '0;
        end else begin
            rd_st_reg <= rd_st_next;
            if (rd_req) begin
                rd_q_pend_reg <= read_queue_addr[QSEL_W-1:0]; // RULE23
            end
            if (rd_st_reg == RD_FILL) begin
                rd_q_reg <= rd_q_pend_reg;
            end
        end
    end

    // Output word stays put once consumed; only the valid flag drops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_out_reg <= '0;
            q_oe_reg  <= 1'b0;
            ov_n_reg  <= 1'b1;
            pr_n_reg  <= 1'b1;
        end else begin
            if (rd_pop) begin
                q_out_reg <= rd_word; // RULE21
            end
            q_oe_reg <= !output_en_n;
            ov_n_reg <= ov_n_next; // RULE4
            pr_n_reg <= !(pkt_mode_reg && ready_vec[rd_q_reg]); // RULE4 RULE17
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            poll_quad_reg <= '0;
            dir_quad_reg  <= '0;
            quad_out_reg  <= '0;
            bus_n_reg     <= 8'hFF;
        end else begin
            poll_quad_reg <= poll_quad_reg + 2'h1;
            dir_quad_reg  <= dir_quad_next; // RULE22
            quad_out_reg  <= quad_cur;
            bus_n_reg     <= bus_n_next;
        end
    end

    // One-cycle answer; waitrequest idles high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h0;
            ctrl_reg  <= CTRL_RESET;
        end else begin
            wait_reg <= !avs_req;
            if (avs_req) begin
                rdata_reg <= reg_mux;
            end
            if (ctrl_wr) begin
                ctrl_reg <= avs_writedata[1:0];
            end
        end
    end

    assign full_flag_n         = full_n_reg;
    assign read_data           = q_out_reg;
    assign read_data_oe        = q_oe_reg;
    assign output_valid_flag_n = ov_n_reg;
    assign packet_ready_flag_n = pr_n_reg;
    assign packet_ready_bus_n  = bus_n_reg;
    assign packet_ready_quad   = quad_out_reg;
    assign avs_readdata        = rdata_reg;
    assign avs_waitrequest     = wait_reg;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_wr_req;
        wr_req;
    endsequence
    sequence s_rd_req;
        rd_req;
    endsequence

    property p_mode_hold;
        latched_reg |=> $stable(pkt_mode_reg) && $stable(flag_mode_reg);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed after latch"); // RULE1

    property p_wr_switch;
        s_wr_req |=> ##1 (wr_q_reg == $past(write_queue_addr[QSEL_W-1:0], 2));
    endproperty
    a_wr_switch: assert property (p_wr_switch) else $error("write queue not switched"); // RULE6

    property p_wr_idle;
        wr_req && write_en_n |-> !wr_push;
    endproperty
    a_wr_idle: assert property (p_wr_idle) else $error("write stored with enable high"); // RULE7

    property p_full_new;
        s_wr_req |=> ##1 (full_flag_n == !$past(full_vec[wr_q_pend_reg]));
    endproperty
    a_full_new: assert property (p_full_new) else $error("full flag not of new queue"); // RULE10

    property p_no_full_write;
        full_vec[wr_q_reg] |-> !wr_push;
    endproperty
    a_no_full_write: assert property (p_no_full_write) else $error("write into full queue"); // RULE11

    property p_rd_idle;
        rd_req && read_en_n |-> !rd_pop;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read taken with enable high"); // RULE13

    property p_rd_fill;
        s_rd_req ##1 (!empty_vec[rd_q_reg] && rd_allow) |-> rd_pop ##1 !output_valid_flag_n;
    endproperty
    a_rd_fill: assert property (p_rd_fill) else $error("filler did not pass"); // RULE15

    property p_pr_flag;
        pkt_mode_reg |=> packet_ready_flag_n == !$past(ready_vec[rd_q_reg]);
    endproperty
    a_pr_flag: assert property (p_pr_flag) else $error("ready flag not of read queue"); // RULE17

    property p_hold_partial;
        pkt_mode_reg && rd_st_reg == RD_NORM && !ready_vec[rd_q_reg]
            && !in_pkt_vec[rd_q_reg] |-> !rd_pop;
    endproperty
    a_hold_partial: assert property (p_hold_partial) else $error("word left before packet"); // RULE18

    property p_markers;
        rd_pop |=> read_data[END_BIT:START_BIT] == $past(rd_word[END_BIT:START_BIT]);
    endproperty
    a_markers: assert property (p_markers) else $error("markers not carried"); // RULE21

    property p_quad;
        !flag_mode_reg && rd_flag_sel |=> packet_ready_quad == $past(read_queue_addr[1:0]);
    endproperty
    a_quad: assert property (p_quad) else $error("quadrant not taken"); // RULE22
endmodule
`default_nettype wire

// [bench/pmq_port_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pmq_port_model
    import pmq_pkg::*;
(
    // Clock
    input  wire logic               clk,
    // Write side
    output var  logic               write_en_n,
    output var  logic [DATA_W-1:0]  write_data,
    output var  logic               write_addr_strobe,
    output var  logic [QADDR_W-1:0] write_queue_addr,
    // Read side
    output var  logic               read_en_n,
    output var  logic               output_en_n,
    output var  logic               read_addr_strobe,
    output var  logic               read_flag_strobe,
    output var  logic [QADDR_W-1:0] read_queue_addr,
    input  wire logic [DATA_W-1:0]  read_data
);
    logic [DATA_W-1:0] got [0:7];

    initial begin
        write_en_n = 1'b1;
        write_data = '0;
        write_addr_strobe = 1'b0;
        write_queue_addr = '0;
        read_en_n = 1'b1;
        output_en_n = 1'b0;
        read_addr_strobe = 1'b0;
        read_flag_strobe = 1'b0;
        read_queue_addr = '0;
    end

    // Released bus shows the inverse so stale data never looks valid
    task automatic wr_idle();
        @(posedge clk);
        write_en_n <= 1'b1;
        write_data <= ~write_data;
    endtask

    task automatic wr_word(input logic [DATA_W-1:0] d);
        @(posedge clk);
        write_en_n <= 1'b0;
        write_data <= d;
        write_addr_strobe <= 1'b0;
    endtask

    // Whole packet of at least four words, 36-bit words with markers on top
    task automatic wr_pkt(input logic [33:0] base, input int n);
        wr_word({2'b01, base});
        for (int i = 1; i < n - 1; i++) wr_word({2'b00, base + 34'(i)});
        wr_word({2'b10, base + 34'(n - 1)});
    endtask

    // Request cycle writes nothing; the next one a marker-free filler
    task automatic wr_switch(input logic [4:0] q, input logic [33:0] fill);
        @(posedge clk);
        write_addr_strobe <= 1'b1;
        write_queue_addr  <= {3'h0, q};
        write_en_n        <= 1'b1;
        write_data        <= ~write_data;
        wr_word({2'b00, fill});
    endtask

    // Called only after a whole packet is out; got[0] is filler to discard
    task automatic rd_switch(input logic [4:0] q);
        @(posedge clk);
        read_addr_strobe <= 1'b1;
        read_queue_addr  <= {3'h0, q};
        read_en_n        <= 1'b1;
        @(posedge clk);
        read_addr_strobe <= 1'b0;
        read_queue_addr  <= ~read_queue_addr;
        @(posedge clk);
        #1 got[0] = read_data;
        @(posedge clk);
        #1 got[1] = read_data;
    endtask

    task automatic rd_n(input int n);
        @(posedge clk);
        read_en_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            if (i == n - 1) read_en_n <= 1'b1;
            #1 got[i] = read_data;
        end
    endtask

    task automatic flag_quad(input logic [1:0] qd);
        @(posedge clk);
        read_flag_strobe <= 1'b1;
        read_queue_addr  <= {6'h00, qd};
        @(posedge clk);
        read_flag_strobe <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, (a), (b)); end end
module tb;
    import pmq_pkg::*;
    logic               clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               packet_select = 1'b1;
    logic               flag_mode_select = 1'b0;
    logic [AVS_AW-1:0]  avs_address;
    logic               avs_read;
    logic               avs_write;
    logic [31:0]        avs_writedata;
    logic [31:0]        avs_readdata;
    logic               avs_waitrequest;
    logic               wen_n, wstb, ren_n, oe_n, rstb, fstb, full_n, oe, ov_n, pr_n;
    logic [DATA_W-1:0]  wdata, rdata;
    logic [QADDR_W-1:0] waddr, raddr;
    logic [7:0]         bus_n;
    logic [1:0]         quad, qa;
    logic [31:0]        rdat;
    logic [7:0]         bus_exp [4] = '{8'hDE, 8'hEF, 8'hFF, 8'hFF};
    int                 fails = 0;
    int                 check_count = 0;

    always #25 clk = ~clk;

    pmq_top #(.DEPTH(8)) u_pmq_top (.clk(clk), .rst_n(rst_n),
        .packet_select(packet_select), .flag_mode_select(flag_mode_select),
        .write_en_n(wen_n), .write_data(wdata), .write_addr_strobe(wstb),
        .write_queue_addr(waddr), .full_flag_n(full_n), .read_en_n(ren_n),
        .output_en_n(oe_n), .read_addr_strobe(rstb), .read_flag_strobe(fstb),
        .read_queue_addr(raddr), .read_data(rdata), .read_data_oe(oe),
        .output_valid_flag_n(ov_n), .packet_ready_flag_n(pr_n),
        .packet_ready_bus_n(bus_n), .packet_ready_quad(quad),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    pmq_port_model u_pmq_port_model (.clk(clk), .write_en_n(wen_n), .write_data(wdata),
        .write_addr_strobe(wstb), .write_queue_addr(waddr), .read_en_n(ren_n),
        .output_en_n(oe_n), .read_addr_strobe(rstb), .read_flag_strobe(fstb),
        .read_queue_addr(raddr), .read_data(rdata));

    function automatic logic [DATA_W-1:0] pw(input logic [33:0] b, input int i, input int n);
        return {i == n - 1, i == 0, b + 34'(i)};
    endfunction

    task automatic avs_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_write <= 1'b1;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask

    task automatic avs_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        avs_read <= 1'b1;
        avs_address <= a;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    initial begin
        avs_address   <= '0;
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        avs_writedata <= '0;
        settle(20);
        rst_n <= 1'b1;
        settle(3);
        `CHK(pr_n, 1'b1)
        u_pmq_port_model.wr_pkt(34'h100, 4);
        u_pmq_port_model.wr_switch(5'd12, 34'h0F0);
        u_pmq_port_model.wr_pkt(34'h200, 8);
        u_pmq_port_model.wr_word({2'b00, 34'h2FF});
        u_pmq_port_model.wr_idle();
        settle(2);
        `CHK(full_n, 1'b0)
        u_pmq_port_model.wr_switch(5'd5, 34'h0FC);
        u_pmq_port_model.wr_idle();
        #1 `CHK(full_n, 1'b1)
        u_pmq_port_model.wr_pkt(34'h300, 5);
        u_pmq_port_model.wr_switch(5'd9, 34'h0F5);
        u_pmq_port_model.wr_word(pw(34'h400, 0, 4));
        u_pmq_port_model.wr_word(pw(34'h400, 1, 4));
        u_pmq_port_model.wr_idle();
        settle(4);
        `CHK(pr_n, 1'b0)
        $display("write queue switching done");
        for (int i = 0; i < 4; i++) begin
            u_pmq_port_model.flag_quad(2'(i));
            `CHK(bus_n, bus_exp[i])
            `CHK(quad, 2'(i))
        end
        $display("ready bus quadrants done");
        u_pmq_port_model.rd_n(4);
        for (int i = 0; i < 4; i++) `CHK(u_pmq_port_model.got[i], pw(34'h100, i, 4))
        `CHK(ov_n, 1'b0)
        `CHK(pr_n, 1'b1)
        u_pmq_port_model.rd_switch(5'd5);
        `CHK(u_pmq_port_model.got[0], {2'b00, 34'h0F0})
        `CHK(u_pmq_port_model.got[1], pw(34'h300, 0, 5))
        u_pmq_port_model.rd_n(4);
        for (int i = 0; i < 4; i++) `CHK(u_pmq_port_model.got[i], pw(34'h300, i + 1, 5))
        u_pmq_port_model.rd_switch(5'd9);
        `CHK(u_pmq_port_model.got[0], {2'b00, 34'h0F5})
        u_pmq_port_model.rd_n(2);
        `CHK(u_pmq_port_model.got[1], {2'b00, 34'h0F5})
        `CHK(ov_n, 1'b1)
        `CHK(pr_n, 1'b1)
        u_pmq_port_model.wr_word(pw(34'h400, 2, 4));
        u_pmq_port_model.wr_word(pw(34'h400, 3, 4));
        u_pmq_port_model.wr_idle();
        settle(4);
        `CHK(pr_n, 1'b0)
        u_pmq_port_model.rd_n(4);
        for (int i = 0; i < 4; i++) `CHK(u_pmq_port_model.got[i], pw(34'h400, i, 4))
        @(posedge clk);
        u_pmq_port_model.output_en_n <= 1'b1;
        settle(2);
        `CHK(oe, 1'b0)
        u_pmq_port_model.output_en_n <= 1'b0;
        $display("read queue switching done");
        avs_rd(OFF_STATUS, rdat);
        `CHK(rdat, 32'h0001_0909)
        avs_rd(OFF_READY, rdat);
        `CHK(rdat, 32'h0000_1000)
        avs_rd(OFF_CTRL, rdat);
        `CHK(rdat, 32'h0000_0003)
        avs_wr(OFF_CTRL, 32'h0000_0001);
        avs_rd(OFF_CTRL, rdat);
        `CHK(rdat, 32'h0000_0001)
        avs_wr(OFF_CTRL, 32'h0000_0003);
        avs_rd(4'hC, rdat);
        `CHK(rdat, 32'h0000_0000)
        $display("register access done");
        @(posedge clk);
        rst_n <= 1'b0;
        packet_select <= 1'b0;
        flag_mode_select <= 1'b1;
        settle(20);
        rst_n <= 1'b1;
        settle(3);
        avs_rd(OFF_STATUS, rdat);
        `CHK(rdat, 32'h0002_0000)
        u_pmq_port_model.wr_pkt(34'h500, 4);
        u_pmq_port_model.wr_idle();
        settle(4);
        `CHK(pr_n, 1'b1)
        qa = quad;
        settle(1);
        `CHK(quad, qa + 2'h1)
        $display("standard mode done");
        complete_run();
    end

    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        complete_run();
    end
endmodule
`default_nettype wire
